// ===== src/gpeh_ports.sv
// General-purpose I/O logic for ports E, F, G and H with a Wishbone slave
`timescale 1ns/1ns
// Functional notes
// R1: Direction one enables the pin driver; zero leaves the pin a high-impedance input.
// R2: Reset clears all eight port E direction bits.
// R3: Port E read gives latch where direction is one, pin level otherwise.
// R4: Data writes always update latches; input pins still read the pin.
// R5: Software should load the latch before turning a direction bit to output.
// R6: Port F has seven read/write latch bits that reset leaves alone.
// R7: Port F pins 3..0 are timer A channels 3..0, pins 5..4 timer B 1..0.
// R8: Timer-owned port F pins ignore direction for driving, keep it for readback.
// R9: Port F read gives latch where direction is one, pin level otherwise.
// R10: Reset clears the seven port F direction bits.
// R11: Port G has three read/write latch bits untouched by reset, each with direction.
// R12: Reset clears the three port G direction bits.
// R13: Port G read gives latch where direction is set, pin level otherwise.
// R14: Keypad enable bits 2..0 turn port G pins into interrupt inputs.
// R15: Port H has a two-bit read/write latch with per-pin direction.
// R16: Keypad enable bits 4..3 turn port H pins into interrupt inputs.
// R17: Reset clears both port H direction bits.
// R18: Port H read gives latch where direction is one, pin level otherwise.
// R19: Peripheral-owned port E pins ignore direction for driving, keep it for readback.
// R20: A peripheral-owned pin takes its drive value and enable from the peripheral.
module gpeh_ports (
  input wire logic CLK,
  input wire logic RST_N,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [gpeh_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Port E pins and peripheral takeover (serial, timer)
  input wire logic [gpeh_pkg::E_W-1:0] PE_IN,
  output logic [gpeh_pkg::E_W-1:0] PE_OUT,
  output logic [gpeh_pkg::E_W-1:0] PE_OE,
  input wire logic [gpeh_pkg::E_W-1:0] PE_PERIPH_OWN,
  input wire logic [gpeh_pkg::E_W-1:0] PE_PERIPH_OUT,
  input wire logic [gpeh_pkg::E_W-1:0] PE_PERIPH_OE,
  // Port F pins and timer channels
  input wire logic [gpeh_pkg::F_W-1:0] PF_IN,
  output logic [gpeh_pkg::F_W-1:0] PF_OUT,
  output logic [gpeh_pkg::F_W-1:0] PF_OE,
  input wire logic [2*gpeh_pkg::F_TIMER_A_N-1:0] TIMER_A_CHANNEL_EDGE_LEVEL_SELECT,
  input wire logic [gpeh_pkg::F_TIMER_A_N-1:0] TIMER_A_CHANNEL_PIN_OUT,
  input wire logic [gpeh_pkg::F_TIMER_A_N-1:0] TIMER_A_CHANNEL_PIN_OE,
  input wire logic [2*gpeh_pkg::F_TIMER_B_N-1:0] TIMER_B_CHANNEL_EDGE_LEVEL_SELECT,
  input wire logic [gpeh_pkg::F_TIMER_B_N-1:0] TIMER_B_CHANNEL_PIN_OUT,
  input wire logic [gpeh_pkg::F_TIMER_B_N-1:0] TIMER_B_CHANNEL_PIN_OE,
  output logic [gpeh_pkg::F_TIMER_A_N-1:0] TIMER_A_CHANNEL_PIN_IN,
  output logic [gpeh_pkg::F_TIMER_B_N-1:0] TIMER_B_CHANNEL_PIN_IN,
  // Port G and H pins and keypad inputs
  input wire logic [gpeh_pkg::G_W-1:0] PG_IN,
  output logic [gpeh_pkg::G_W-1:0] PG_OUT,
  output logic [gpeh_pkg::G_W-1:0] PG_OE,
  input wire logic [gpeh_pkg::H_W-1:0] PH_IN,
  output logic [gpeh_pkg::H_W-1:0] PH_OUT,
  output logic [gpeh_pkg::H_W-1:0] PH_OE,
  input wire logic [gpeh_pkg::KEYPAD_N-1:0] KEYPAD_INTERRUPT_ENABLE,
  output logic [gpeh_pkg::KEYPAD_N-1:0] KEYPAD_INPUT
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] readback(input logic [7:0] dir, input logic [7:0] latch,
                                          input logic [7:0] pin);
    readback = (dir & latch) | (~dir & pin);
  endfunction

  // Register select, shared by every write strobe
  function automatic logic reg_hit(input logic [3:0] sel_idx, input logic [3:0] target);
    reg_hit = (sel_idx == target);
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [gpeh_pkg::E_W-1:0] port_e_data_ff;
  logic [gpeh_pkg::F_W-1:0] port_f_data_ff;
  logic [gpeh_pkg::G_W-1:0] port_g_data_ff;
  logic [gpeh_pkg::H_W-1:0] port_h_data_ff;
  logic [gpeh_pkg::E_W-1:0] port_e_direction_ff;
  logic [gpeh_pkg::F_W-1:0] port_f_direction_ff;
  logic [gpeh_pkg::G_W-1:0] port_g_direction_ff;
  logic [gpeh_pkg::H_W-1:0] port_h_direction_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic req;
  logic wr_now;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic [gpeh_pkg::F_W-1:0] f_owned;
  logic [gpeh_pkg::F_W-1:0] f_periph_out;
  logic [gpeh_pkg::F_W-1:0] f_periph_oe;
  logic [gpeh_pkg::KEYPAD_N-1:0] kbd_gh_pins;
  logic nxt_ack;
  logic take_req;
  logic lane0;
  logic wr_e_data;
  logic wr_f_data;
  logic wr_g_data;
  logic wr_h_data;
  logic wr_e_dir;
  logic wr_f_dir;
  logic wr_g_dir;
  logic wr_h_dir;
  logic [7:0] rd_e;
  logic [7:0] rd_f;
  logic [7:0] rd_g;
  logic [7:0] rd_h;
  logic [gpeh_pkg::G_W-1:0] g_keypad_on;
  logic [gpeh_pkg::H_W-1:0] h_keypad_on;

  assign req = WB_CYC_I & WB_STB_I;
  assign idx = WB_ADR_I[gpeh_pkg::IDX_LSB +: 4];
  assign wbyte = WB_DAT_I[7:0];
  // Only byte lane 0 carries a register; other lanes are ignored
  assign lane0 = WB_SEL_I[0];
  // Write lands on the edge where the master samples ack
  assign wr_now = req & WB_WE_I & ack_ff & lane0;
  // Capture once per access, so read data stands until the next one
  assign take_req = req & ~ack_ff;
  assign nxt_ack = take_req;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (take_req) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;

  // ------------------------------------------------------------
  // Per-port readback, direction picks latch or pin
  // ------------------------------------------------------------
  assign rd_e = readback(port_e_direction_ff, port_e_data_ff, PE_IN);
  assign rd_f = readback({1'b0, port_f_direction_ff}, {1'b0, port_f_data_ff},
                         {1'b0, PF_IN});
  assign rd_g = readback({5'h00, port_g_direction_ff}, {5'h00, port_g_data_ff},
                         {5'h00, PG_IN});
  assign rd_h = readback({6'h00, port_h_direction_ff}, {6'h00, port_h_data_ff},
                         {6'h00, PH_IN});

  // ------------------------------------------------------------
  // Read mux, unmapped and reserved bits read zero
  // ------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      // R3: port E latch or pin
      gpeh_pkg::IDX_PORT_E_DATA: begin
        nxt_rdata[7:0] = rd_e;
      end
      // R9: port F latch or pin, R8 kept for timer pins
      gpeh_pkg::IDX_PORT_F_DATA: begin
        nxt_rdata[7:0] = rd_f;
      end
      // R13: port G latch or pin
      gpeh_pkg::IDX_PORT_G_DATA: begin
        nxt_rdata[7:0] = rd_g;
      end
      // R18: port H latch or pin
      gpeh_pkg::IDX_PORT_H_DATA: begin
        nxt_rdata[7:0] = rd_h;
      end
      gpeh_pkg::IDX_PORT_E_DIRECTION: begin
        nxt_rdata[7:0] = port_e_direction_ff;
      end
      gpeh_pkg::IDX_PORT_F_DIRECTION: begin
        nxt_rdata[6:0] = port_f_direction_ff;
      end
      gpeh_pkg::IDX_PORT_G_DIRECTION: begin
        nxt_rdata[2:0] = port_g_direction_ff;
      end
      gpeh_pkg::IDX_PORT_H_DIRECTION: begin
        nxt_rdata[1:0] = port_h_direction_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Write strobes, one per register
  // ------------------------------------------------------------
  assign wr_e_data = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_E_DATA);
  assign wr_f_data = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_F_DATA);
  assign wr_g_data = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_G_DATA);
  assign wr_h_data = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_H_DATA);
  assign wr_e_dir = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_E_DIRECTION);
  assign wr_f_dir = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_F_DIRECTION);
  assign wr_g_dir = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_G_DIRECTION);
  assign wr_h_dir = wr_now & reg_hit(idx, gpeh_pkg::IDX_PORT_H_DIRECTION);

  // ------------------------------------------------------------
  // Data latches, no reset so contents survive it
  // ------------------------------------------------------------
  // R4: latches written whatever the direction
  always_ff @(posedge CLK) begin
    if (wr_e_data) begin
      port_e_data_ff <= wbyte;
    end
  end

  // R6: port F latch untouched by reset
  always_ff @(posedge CLK) begin
    if (wr_f_data) begin
      port_f_data_ff <= wbyte[gpeh_pkg::F_W-1:0];
    end
  end

  // R11: port G latch untouched by reset
  always_ff @(posedge CLK) begin
    if (wr_g_data) begin
      port_g_data_ff <= wbyte[gpeh_pkg::G_W-1:0];
    end
  end

  // R15: port H two-bit latch
  always_ff @(posedge CLK) begin
    if (wr_h_data) begin
      port_h_data_ff <= wbyte[gpeh_pkg::H_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Direction registers
  // ------------------------------------------------------------
  // Reset wins, so a write in a reset cycle is lost
  // R2: port E directions cleared
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      port_e_direction_ff <= gpeh_pkg::PORT_E_DIRECTION_RST;
    end else if (wr_e_dir) begin
      port_e_direction_ff <= wbyte;
    end
  end

  // R10: port F directions cleared
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      port_f_direction_ff <= gpeh_pkg::PORT_F_DIRECTION_RST;
    end else if (wr_f_dir) begin
      port_f_direction_ff <= wbyte[gpeh_pkg::F_W-1:0];
    end
  end

  // R12: port G directions cleared
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      port_g_direction_ff <= gpeh_pkg::PORT_G_DIRECTION_RST;
    end else if (wr_g_dir) begin
      port_g_direction_ff <= wbyte[gpeh_pkg::G_W-1:0];
    end
  end

  // R17: port H directions cleared
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      port_h_direction_ff <= gpeh_pkg::PORT_H_DIRECTION_RST;
    end else if (wr_h_dir) begin
      port_h_direction_ff <= wbyte[gpeh_pkg::H_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Port F timer ownership
  // ------------------------------------------------------------
  // R7: a nonzero edge/level select hands the pin to its channel
  always_comb begin
    f_owned = '0;
    f_periph_out = '0;
    f_periph_oe = '0;
    for (int i = 0; i < gpeh_pkg::F_TIMER_A_N; i++) begin
      f_owned[gpeh_pkg::F_TIMER_A_LSB + i] = |TIMER_A_CHANNEL_EDGE_LEVEL_SELECT[2*i +: 2];
      f_periph_out[gpeh_pkg::F_TIMER_A_LSB + i] = TIMER_A_CHANNEL_PIN_OUT[i];
      f_periph_oe[gpeh_pkg::F_TIMER_A_LSB + i] = TIMER_A_CHANNEL_PIN_OE[i];
    end
    for (int i = 0; i < gpeh_pkg::F_TIMER_B_N; i++) begin
      f_owned[gpeh_pkg::F_TIMER_B_LSB + i] = |TIMER_B_CHANNEL_EDGE_LEVEL_SELECT[2*i +: 2];
      f_periph_out[gpeh_pkg::F_TIMER_B_LSB + i] = TIMER_B_CHANNEL_PIN_OUT[i];
      f_periph_oe[gpeh_pkg::F_TIMER_B_LSB + i] = TIMER_B_CHANNEL_PIN_OE[i];
    end
  end

  // Timers always see the pin, owned or not
  assign TIMER_A_CHANNEL_PIN_IN = PF_IN[gpeh_pkg::F_TIMER_A_LSB +: gpeh_pkg::F_TIMER_A_N];
  assign TIMER_B_CHANNEL_PIN_IN = PF_IN[gpeh_pkg::F_TIMER_B_LSB +: gpeh_pkg::F_TIMER_B_N];

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // R1: direction bit gates the driver
  // R19: serial and timer pins of port E bypass direction
  // R20: owner supplies value and enable
  // Drive values follow the latch even while the driver is off
  assign PE_OUT = (PE_PERIPH_OWN & PE_PERIPH_OUT) | (~PE_PERIPH_OWN & port_e_data_ff);
  assign PE_OE = (PE_PERIPH_OWN & PE_PERIPH_OE) | (~PE_PERIPH_OWN & port_e_direction_ff);

  // R8: timer-owned port F pins bypass direction
  assign PF_OUT = (f_owned & f_periph_out) | (~f_owned & port_f_data_ff);
  assign PF_OE = (f_owned & f_periph_oe) | (~f_owned & port_f_direction_ff);

  // R14: keypad-enabled port G pins become inputs
  // R16: keypad-enabled port H pins become inputs
  assign PG_OUT = port_g_data_ff;
  assign g_keypad_on = KEYPAD_INTERRUPT_ENABLE[gpeh_pkg::KEYPAD_G_LSB +: gpeh_pkg::G_W];
  assign h_keypad_on = KEYPAD_INTERRUPT_ENABLE[gpeh_pkg::KEYPAD_H_LSB +: gpeh_pkg::H_W];
  // Keypad pins must not fight the key matrix, so the driver is forced off
  assign PG_OE = port_g_direction_ff & ~g_keypad_on;
  assign PH_OUT = port_h_data_ff;
  assign PH_OE = port_h_direction_ff & ~h_keypad_on;

  // Keypad sees the pin only while its enable is set
  assign kbd_gh_pins = {PH_IN, PG_IN};
  assign KEYPAD_INPUT = kbd_gh_pins & KEYPAD_INTERRUPT_ENABLE;

endmodule

// ===== src/gpeh_pkg.sv
// Package with register map and reset values of the port E to H block
package gpeh_pkg;
  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_PORT_E_DATA = 4'h8;
  localparam logic [3:0] IDX_PORT_F_DATA = 4'h9;
  localparam logic [3:0] IDX_PORT_G_DATA = 4'hA;
  localparam logic [3:0] IDX_PORT_H_DATA = 4'hB;
  localparam logic [3:0] IDX_PORT_E_DIRECTION = 4'hC;
  localparam logic [3:0] IDX_PORT_F_DIRECTION = 4'hD;
  localparam logic [3:0] IDX_PORT_G_DIRECTION = 4'hE;
  localparam logic [3:0] IDX_PORT_H_DIRECTION = 4'hF;
  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int E_W = 8;
  localparam int F_W = 7;
  localparam int G_W = 3;
  localparam int H_W = 2;
  localparam int ADR_W = 6;
  localparam int IDX_LSB = 2;
  localparam logic [E_W-1:0] PORT_E_DIRECTION_RST = 8'h00;
  localparam logic [F_W-1:0] PORT_F_DIRECTION_RST = 7'h00;
  localparam logic [G_W-1:0] PORT_G_DIRECTION_RST = 3'h0;
  localparam logic [H_W-1:0] PORT_H_DIRECTION_RST = 2'h0;
  // ------------------------------------------------------------
  // Field positions of peripheral pins
  // ------------------------------------------------------------
  localparam int F_TIMER_A_LSB = 0;
  localparam int F_TIMER_A_N = 4;
  localparam int F_TIMER_B_LSB = 4;
  localparam int F_TIMER_B_N = 2;
  localparam int KEYPAD_G_LSB = 0;
  localparam int KEYPAD_H_LSB = 3;
  localparam int KEYPAD_N = 5;
endpackage

// ===== tb/gpeh_pin_model.sv
// Board-side model of one port's pins
`timescale 1ns/1ns
module gpeh_pin_model #(parameter int W = 8) (
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] board,
  output logic [W-1:0] pin
);
  // No pull resistors: a released pin shows the board level, never the old drive
  assign pin = (drv & oe) | (board & ~oe);
endmodule

// ===== tb/gpeh_ports_props.sv
// Concurrent checks on the port E to H block ports
`timescale 1ns/1ns
module gpeh_ports_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [gpeh_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [7:0] PE_OE,
  input wire logic [7:0] PE_PERIPH_OWN,
  input wire logic [6:0] PF_OE,
  input wire logic [7:0] TIMER_A_CHANNEL_EDGE_LEVEL_SELECT,
  input wire logic [3:0] TIMER_A_CHANNEL_PIN_OE,
  input wire logic [2:0] PG_IN,
  input wire logic [2:0] PG_OUT,
  input wire logic [2:0] PG_OE,
  input wire logic [1:0] PH_IN,
  input wire logic [1:0] PH_OE,
  input wire logic [4:0] KEYPAD_INTERRUPT_ENABLE,
  input wire logic [4:0] KEYPAD_INPUT
);
  logic [7:0] ta;
  logic [3:0] own_a;
  logic wr_ok;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  assign ta = TIMER_A_CHANNEL_EDGE_LEVEL_SELECT;
  // Any nonzero select field hands the pin to timer A
  assign own_a = {|ta[7:6], |ta[5:4], |ta[3:2], |ta[1:0]};
  assign wr_ok = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  chk_ack_follows: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_unmapped_zero: assert property (
    WB_ACK_O && !WB_WE_I && !WB_ADR_I[5] |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_dir_reset: assert property (
    $rose(RST_N) |-> PG_OE == 3'h0 && PH_OE == 2'h0 && (PE_OE & ~PE_PERIPH_OWN) == 8'h0)
    else $error("driver enabled right after reset");
  chk_g_latch: assert property (
    wr_ok && WB_ADR_I[5:2] == gpeh_pkg::IDX_PORT_G_DATA |=> PG_OUT == $past(WB_DAT_I[2:0]))
    else $error("port G latch not updated by write");
  chk_g_drive: assert property (
    wr_ok && WB_ADR_I[5:2] == gpeh_pkg::IDX_PORT_G_DIRECTION
    |=> PG_OE == ($past(WB_DAT_I[2:0]) & ~KEYPAD_INTERRUPT_ENABLE[2:0]))
    else $error("port G enable does not follow direction");
  chk_timer_drive: assert property (
    |own_a |-> (PF_OE[3:0] & own_a) == (TIMER_A_CHANNEL_PIN_OE & own_a))
    else $error("timer-owned pin enable not from timer");
  chk_keypad_route: assert property (
    |KEYPAD_INTERRUPT_ENABLE |-> KEYPAD_INPUT == ({PH_IN, PG_IN} & KEYPAD_INTERRUPT_ENABLE)
    && (PH_OE & KEYPAD_INTERRUPT_ENABLE[4:3]) == 2'h0)
    else $error("keypad routing wrong");
endmodule

// ===== tb/gpeh_ports_bench.sv
// Self-checking bench for the port E to H block
`timescale 1ns/1ns
module gpeh_ports_bench;
  logic clk, rst_n, cyc, stb, we, ack;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o;
  logic [7:0] ext, q, e_in, e_out, e_oe, own_e, per_out, per_oe, ta_sel;
  logic [6:0] f_in, f_out, f_oe;
  logic [3:0] ta_out, ta_oe, ta_in, tb_sel;
  logic [2:0] g_in, g_out, g_oe;
  logic [1:0] h_in, h_out, h_oe, tb_out, tb_oe, tb_in;
  logic [4:0] kb_en, kb_in;
  logic [7:0] masks [4] = '{8'hFF, 8'h7F, 8'h07, 8'h03};
  int fails = 0;
  int checked = 0;
  gpeh_ports u_gpeh_ports (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .PE_IN(e_in), .PE_OUT(e_out), .PE_OE(e_oe), .PE_PERIPH_OWN(own_e),
    .PE_PERIPH_OUT(per_out), .PE_PERIPH_OE(per_oe), .PF_IN(f_in), .PF_OUT(f_out), .PF_OE(f_oe),
    .TIMER_A_CHANNEL_EDGE_LEVEL_SELECT(ta_sel), .TIMER_A_CHANNEL_PIN_OUT(ta_out),
    .TIMER_A_CHANNEL_PIN_OE(ta_oe), .TIMER_B_CHANNEL_EDGE_LEVEL_SELECT(tb_sel),
    .TIMER_B_CHANNEL_PIN_OUT(tb_out), .TIMER_B_CHANNEL_PIN_OE(tb_oe), .TIMER_A_CHANNEL_PIN_IN(ta_in),
    .TIMER_B_CHANNEL_PIN_IN(tb_in), .PG_IN(g_in), .PG_OUT(g_out), .PG_OE(g_oe), .PH_IN(h_in),
    .PH_OUT(h_out), .PH_OE(h_oe), .KEYPAD_INTERRUPT_ENABLE(kb_en), .KEYPAD_INPUT(kb_in));
  gpeh_pin_model #(.W(8)) u_gpeh_pin_model_e (.drv(e_out), .oe(e_oe), .board(ext), .pin(e_in));
  gpeh_pin_model #(.W(7)) u_gpeh_pin_model_f (.drv(f_out), .oe(f_oe), .board(ext[6:0]), .pin(f_in));
  gpeh_pin_model #(.W(3)) u_gpeh_pin_model_g (.drv(g_out), .oe(g_oe), .board(ext[2:0]), .pin(g_in));
  gpeh_pin_model #(.W(2)) u_gpeh_pin_model_h (.drv(h_out), .oe(h_oe), .board(ext[1:0]), .pin(h_in));
  // ----------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Classic single cycle; ack sampled at the rising edge, read data taken there
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    // One wait state, ack at the second edge
    cmp(32'(n), 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    {cyc, stb, we, adr, wdat, own_e, per_out, per_oe, ta_sel, ta_out, ta_oe} = '0;
    {tb_sel, tb_out, tb_oe, kb_en} = '0;
    sel = 4'h1;
    rst_n = 1'b0;
    ext = 8'h3C;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      wb(1'b0, 6'(48 + 4 * p), 8'h00);
      cmp(q, 32'h0);
    end
    wb(1'b1, 6'h0C, 8'hFF);
    wb(1'b0, 6'h0C, 8'h00);
    cmp(q, 32'h0);
    $display("Test reset and unmapped done");
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, 6'(32 + 4 * p), 8'hA5);
      wb(1'b0, 6'(32 + 4 * p), 8'h00);
      cmp(q, ext & masks[p]);
      wb(1'b1, 6'(48 + 4 * p), 8'h0F);
      wb(1'b0, 6'(48 + 4 * p), 8'h00);
      cmp(q, 8'h0F & masks[p]);
      wb(1'b0, 6'(32 + 4 * p), 8'h00);
      cmp(q, (8'h05 | (ext & 8'hF0)) & masks[p]);
    end
    cmp({h_oe, g_oe, f_oe, e_oe, h_out, g_out, f_out[3:0]}, {20'hF8F0F, 2'h1, 3'h5, 4'h5});
    $display("Test direction and readback done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp({h_out, g_out, f_out, h_oe, g_oe, f_oe, e_oe}, {2'h1, 3'h5, 7'h25, 20'h0});
    $display("Test second reset done");
    @(posedge clk);
    ta_sel <= 8'h01;
    ta_oe <= 4'h1;
    tb_sel <= 4'h4;
    own_e <= 8'h80;
    per_oe <= 8'h80;
    kb_en <= 5'h1F;
    ext <= 8'h3E;
    wb(1'b1, 6'h34, 8'h7F);
    wb(1'b0, 6'h24, 8'h00);
    cmp(q, 32'h25);
    wb(1'b0, 6'h20, 8'h00);
    cmp(q, 32'h3E);
    @(negedge clk);
    cmp({f_oe, e_oe, e_out[7]}, {7'h5F, 8'h80, 1'b0});
    cmp({kb_in, h_oe, g_oe}, {5'h16, 5'h0});
    cmp({ta_in, tb_in}, {4'h4, 2'h2});
    $display("Test peripheral takeover done");
    summarize();
  end
endmodule
bind gpeh_ports gpeh_ports_props u_gpeh_ports_props (.CLK, .RST_N, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .PE_OE, .PE_PERIPH_OWN, .PF_OE,
  .TIMER_A_CHANNEL_EDGE_LEVEL_SELECT, .TIMER_A_CHANNEL_PIN_OE, .PG_IN, .PG_OUT, .PG_OE, .PH_IN,
  .PH_OE, .KEYPAD_INTERRUPT_ENABLE, .KEYPAD_INPUT);
